// ===== inc/acs_pkg.sv
// Constants and carrier types for the conversion sequencer
// What this block does
// (R01) Isolated pin: driver off, input, pullup off
// (R02) Isolated pin reads as zero
// (R03) Hardware trigger rising edge starts conversion
// (R04) Trigger edge ignored while converting
// (R05) Continuous hardware mode: only first edge counts
// (R06) Resolution selects 10-bit or 8-bit
// (R07) Software mode: control-one write starts conversion
// (R08) Continuous mode restarts after each transfer
// (R09) Completion writes result, sets flag, interrupts
// (R10) High read, low unread: block transfer; the code blocks this way in 10-bit mode only, never in 8-bit mode
// (R11) Blocked transfer restarts, except failed single compare
// (R12) Software avoids result reads mid-conversion
// (R13) Control-one write aborts, restarts unless disabled
// (R14) Control-two, configuration and compare-value writes abort conversion
// (R15) Reset or stop without async clock aborts
// (R16) Abort keeps last result; reset clears it
// (R17) Idle until start; async clock enabled then
// (R18) Short sample: 20/23 clocks plus 5 bus
// (R19) Long sample: 40/43 clocks plus 5 bus
// (R20) Async clock adds 5 us startup
// (R21) Compare: greater-equal or less by subtraction
// (R22) Successful compare stores the difference
// (R23) Failed compare: no flag, no update
// (R24) Wait mode: conversions continue, interrupt wakes
// (R25) Bus, half bus, async clocks usable in wait
// (R26) Disabled by reset or channel all ones
// (R27) 10-bit spans both bytes; 8-bit low only
// (R28) Trigger input synchronised before edge detect
// (R29) Sample phase, approximation phase, then transfer
package acs_pkg;
    // Register word offsets (byte addresses)
    localparam logic [4:0] ACS_OFF_SC1 = 5'h00;
    localparam logic [4:0] ACS_OFF_SC2 = 5'h04;
    localparam logic [4:0] ACS_OFF_RH = 5'h08;
    localparam logic [4:0] ACS_OFF_RL = 5'h0c;
    localparam logic [4:0] ACS_OFF_CVH = 5'h10;
    localparam logic [4:0] ACS_OFF_CVL = 5'h14;
    localparam logic [4:0] ACS_OFF_CFG = 5'h18;
    localparam logic [4:0] ACS_OFF_PIN = 5'h1c;
    // Control one fields
    localparam int ACS_SC1_FLAG = 7;
    localparam int ACS_SC1_IEN = 6;
    localparam int ACS_SC1_CONT = 5;
    localparam logic [4:0] ACS_CH_OFF = 5'h1f;
    // Control two fields
    localparam int ACS_SC2_ACT = 7;
    localparam int ACS_SC2_TRG = 6;
    localparam int ACS_SC2_CFE = 5;
    localparam int ACS_SC2_CGT = 4;
    // Configuration fields
    localparam int ACS_CFG_LSMP = 4;
    localparam int ACS_CFG_MODE = 2;
    localparam logic [1:0] ACS_MODE_8 = 2'h0;
    localparam logic [1:0] ACS_MODE_10 = 2'h2;
    localparam logic [1:0] ACS_CLK_ASYNC = 2'h3;
    localparam logic [1:0] ACS_CLK_HALF = 2'h1;
    // Reset values
    localparam logic [7:0] ACS_RST_SC1 = 8'h1f;
    localparam logic [7:0] ACS_RST_BYTE = 8'h00;
    // Converter clock cycles per conversion; transfer extra counted in bus clocks
    localparam logic [5:0] ACS_SHORT_8 = 6'd20;
    localparam logic [5:0] ACS_SHORT_10 = 6'd23;
    localparam logic [5:0] ACS_LONG_8 = 6'd40;
    localparam logic [5:0] ACS_LONG_10 = 6'd43;
    localparam logic [5:0] ACS_SAMPLE_SHORT = 6'd3;
    localparam logic [5:0] ACS_SAMPLE_LONG = 6'd23;
    localparam logic [2:0] ACS_BUS_EXTRA = 3'd5;
    // Async clock startup time
    localparam int ACS_CLK_MHZ = 250;
    localparam int ACS_STARTUP_US = 5;
    localparam logic [10:0] ACS_STARTUP_CYC = 11'(ACS_STARTUP_US * ACS_CLK_MHZ);
    // Sequencer states
    typedef enum logic [2:0] {
        ACS_IDLE = 3'b000,
        ACS_START = 3'b001,
        ACS_SAMPLE = 3'b010,
        ACS_APPROX = 3'b011,
        ACS_XFER = 3'b100
    } acs_state_t;
    // Software visible registers
    typedef struct packed {
        logic [7:0] sc1;
        logic [7:0] sc2;
        logic [7:0] cfg;
        logic [7:0] cvh;
        logic [7:0] cvl;
        logic [7:0] rh;
        logic [7:0] rl;
        logic [23:0] pin;
    } acs_regs_t;
    // Complete state of the block
    typedef struct packed {
        acs_regs_t r;
        acs_state_t st;
        logic [10:0] cnt;
        logic [3:0] div;
        logic hi_read;
        logic first;
        logic trg_s1;
        logic trg_s2;
        logic trg_s3;
        logic ack;
        logic [31:0] dat;
    } acs_all_t;
endpackage

// ===== rtl/acs_seq.sv
// Conversion sequencer with Wishbone register slave
`timescale 1ns/1ps
module acs_seq
    import acs_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Analog side
    input wire logic hw_trigger_in_i,
    input wire logic [9:0] conv_data_i,
    input wire logic stop_i,
    output logic sample_o,
    output logic async_clk_en_o,
    output logic [4:0] channel_o,
    output logic irq_o,
    // Port pin gating
    input wire logic [23:0] port_in_i,
    output logic [23:0] port_rd_o,
    output logic [23:0] port_oe_allow_o,
    output logic [23:0] pullup_allow_o,
    output logic [23:0] ibuf_en_o
);
    acs_all_t q; // Registered state
    acs_all_t next_q; // Next state
    logic wr; // Accepted write strobe
    logic rd; // Accepted read strobe
    logic conv_tick; // Converter clock enable
    logic busy; // Conversion in progress
    logic trg_edge; // Synchronised rising trigger edge
    logic [10:0] diff; // Compare difference, carry in top bit
    logic cmp_ok; // Compare condition
    logic is10; // 10-bit resolution
    logic [5:0] total; // Total converter cycles
    logic [5:0] samp; // Sampling cycles
    logic [9:0] res; // Truncated result
    logic [9:0] cv; // Compare value
    logic done; // Completion sets the flag this cycle

    // Per-pin isolation controls
    genvar g;
    generate
        for (g = 0; g < 24; g++)
        begin : g_pin
            assign port_oe_allow_o[g] = ~q.r.pin[g]; // [R01]
            assign pullup_allow_o[g] = ~q.r.pin[g]; // [R01]
            assign ibuf_en_o[g] = ~q.r.pin[g]; // [R01]
            assign port_rd_o[g] = port_in_i[g] & ~q.r.pin[g]; // [R02]
        end
    endgenerate

    // Derived combinational terms
    always_comb
    begin
        is10 = (q.r.cfg[ACS_CFG_MODE +: 2] == ACS_MODE_10); // [R06]
        res = is10 ? conv_data_i : {2'h0, conv_data_i[9:2]}; // [R27]
        cv = is10 ? {q.r.cvh[1:0], q.r.cvl} : {2'h0, q.r.cvl};
        diff = {1'b0, res} + {1'b0, ~cv} + 11'h001; // [R21]
        cmp_ok = q.r.sc2[ACS_SC2_CGT] ? diff[10] : ~diff[10]; // [R21]
        if (q.r.cfg[ACS_CFG_LSMP])
        begin
            total = is10 ? ACS_LONG_10 : ACS_LONG_8; // [R19]
            samp = ACS_SAMPLE_LONG;
        end
        else
        begin
            total = is10 ? ACS_SHORT_10 : ACS_SHORT_8; // [R18]
            samp = ACS_SAMPLE_SHORT;
        end
        busy = (q.st != ACS_IDLE);
        trg_edge = q.trg_s2 & ~q.trg_s3; // [R28]
        // Converter clock: bus, or bus halved, divided by the divide field
        // Halved clock doubles the count; divide-by-8 halved wraps to fifteen
        conv_tick = (q.div == (4'h1 << ({1'b0, q.r.cfg[6:5]} +
                     3'(q.r.cfg[1:0] == ACS_CLK_HALF))) - 4'h1); // [R25]
        wr = cyc_i & stb_i & we_i & ~q.ack & sel_i[0];
        rd = cyc_i & stb_i & ~we_i & ~q.ack;
    end

    // Next state logic
    always_comb
    begin
        next_q = q;
        done = 1'b0;
        next_q.ack = cyc_i & stb_i & ~q.ack;
        next_q.trg_s1 = hw_trigger_in_i;
        next_q.trg_s2 = q.trg_s1;
        next_q.trg_s3 = q.trg_s2;
        next_q.div = conv_tick ? 4'h0 : q.div + 4'h1;
        // Sequencer
        case (q.st)
            ACS_IDLE:
            begin
                // Edges are only taken while idle [R04] [R05]
                if (q.r.sc2[ACS_SC2_TRG] && trg_edge && q.r.sc1[4:0] != ACS_CH_OFF)
                begin
                    next_q.st = ACS_START; // [R03]
                    next_q.first = 1'b1;
                    next_q.cnt = 11'h0;
                end
            end
            ACS_START:
            begin
                // Async clock startup delay before first sample [R17] [R20]
                if (q.r.cfg[1:0] != ACS_CLK_ASYNC || q.cnt >= ACS_STARTUP_CYC)
                begin
                    next_q.st = ACS_SAMPLE;
                    next_q.cnt = 11'h0;
                end
                else
                begin
                    next_q.cnt = q.cnt + 11'h1;
                end
            end
            ACS_SAMPLE:
            begin
                if (conv_tick)
                begin
                    next_q.cnt = q.cnt + 11'h1;
                    if (q.cnt[5:0] == samp - 6'd1)
                    begin
                        next_q.st = ACS_APPROX; // [R29]
                    end
                end
            end
            ACS_APPROX:
            begin
                if (conv_tick)
                begin
                    next_q.cnt = q.cnt + 11'h1;
                    if (q.cnt[5:0] == total - 6'd1)
                    begin
                        next_q.st = ACS_XFER; // [R29]
                        next_q.cnt = 11'h0;
                    end
                end
            end
            ACS_XFER:
            begin
                next_q.cnt = q.cnt + 11'h1;
                if (q.cnt[2:0] == ACS_BUS_EXTRA - 3'd1)
                begin
                    next_q.cnt = 11'h0;
                    next_q.first = 1'b0;
                    if (q.r.sc2[ACS_SC2_CFE] && !cmp_ok)
                    begin
                        // Failed compare: nothing stored [R23]
                        next_q.st = (q.r.sc1[ACS_SC1_CONT] || (is10 && q.hi_read)) &&
                                    !(!q.r.sc1[ACS_SC1_CONT]) ? ACS_SAMPLE : ACS_IDLE; // [R11]
                    end
                    else if (is10 && q.hi_read)
                    begin
                        next_q.st = ACS_SAMPLE; // [R10] [R11]
                    end
                    else
                    begin
                        next_q.r.sc1[ACS_SC1_FLAG] = 1'b1; // [R09] [R24]
                        done = 1'b1;
                        if (q.r.sc2[ACS_SC2_CFE])
                        begin
                            next_q.r.rh = is10 ? {6'h0, diff[9:8]} : ACS_RST_BYTE; // [R22]
                            next_q.r.rl = diff[7:0]; // [R22]
                        end
                        else
                        begin
                            next_q.r.rh = is10 ? {6'h0, res[9:8]} : ACS_RST_BYTE; // [R27]
                            next_q.r.rl = res[7:0]; // [R27]
                        end
                        next_q.st = q.r.sc1[ACS_SC1_CONT] ? ACS_SAMPLE : ACS_IDLE; // [R08]
                    end
                end
            end
            default:
            begin
                next_q.st = ACS_IDLE;
            end
        endcase
        // Stop without the async clock aborts, result kept [R15] [R16]
        if (stop_i && q.r.cfg[1:0] != ACS_CLK_ASYNC)
        begin
            next_q.st = ACS_IDLE;
        end
        // Register reads: high-then-low tracking
        if (rd && adr_i == ACS_OFF_RH)
        begin
            next_q.hi_read = 1'b1; // [R10]
        end
        if (rd && adr_i == ACS_OFF_RL)
        begin
            next_q.hi_read = 1'b0;
        end
        // Register writes
        if (wr)
        begin
            case (adr_i)
                ACS_OFF_SC1:
                begin
                    next_q.r.sc1[6:0] = dat_i[6:0];
                    next_q.r.sc1[ACS_SC1_FLAG] = 1'b0;
                    next_q.st = ACS_IDLE; // [R13]
                    if (dat_i[4:0] != ACS_CH_OFF && !q.r.sc2[ACS_SC2_TRG])
                    begin
                        next_q.st = ACS_START; // [R07] [R13] [R26]
                        next_q.first = 1'b1;
                        next_q.cnt = 11'h0;
                    end
                end
                ACS_OFF_SC2:
                begin
                    next_q.r.sc2 = {1'b0, dat_i[6:4], 4'h0};
                    next_q.st = ACS_IDLE; // [R14]
                end
                ACS_OFF_CFG:
                begin
                    next_q.r.cfg = dat_i[7:0];
                    next_q.st = ACS_IDLE; // [R14]
                end
                ACS_OFF_CVH:
                begin
                    next_q.r.cvh = {6'h0, dat_i[1:0]};
                    next_q.st = ACS_IDLE; // [R14]
                end
                ACS_OFF_CVL:
                begin
                    next_q.r.cvl = dat_i[7:0];
                    next_q.st = ACS_IDLE; // [R14]
                end
                ACS_OFF_PIN:
                begin
                    next_q.r.pin = dat_i[23:0];
                end
                default:
                begin
                    next_q.r = q.r;
                end
            endcase
        end
        // Reading the low result clears the flag; a completion in the same cycle wins
        if (rd && adr_i == ACS_OFF_RL && !done)
        begin
            next_q.r.sc1[ACS_SC1_FLAG] = 1'b0;
        end
        // Active flag mirrors the sequencer
        next_q.r.sc2[ACS_SC2_ACT] = (next_q.st != ACS_IDLE);
        // Read data
        case (adr_i)
            ACS_OFF_SC1: next_q.dat = {24'h0, q.r.sc1};
            ACS_OFF_SC2: next_q.dat = {24'h0, q.r.sc2};
            ACS_OFF_RH: next_q.dat = {24'h0, q.r.rh};
            ACS_OFF_RL: next_q.dat = {24'h0, q.r.rl};
            ACS_OFF_CVH: next_q.dat = {24'h0, q.r.cvh};
            ACS_OFF_CVL: next_q.dat = {24'h0, q.r.cvl};
            ACS_OFF_CFG: next_q.dat = {24'h0, q.r.cfg};
            ACS_OFF_PIN: next_q.dat = {8'h0, q.r.pin};
            default: next_q.dat = 32'h0;
        endcase
    end

    // State register; reset returns results to reset values [R16]
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q <= '0; // [R15] [R26]
            q.r.sc1 <= ACS_RST_SC1;
        end
        else if (ce_i)
        begin
            q <= next_q;
        end
    end

    // Outputs
    assign dat_o = q.dat;
    assign ack_o = q.ack;
    assign sample_o = (q.st == ACS_SAMPLE);
    assign async_clk_en_o = busy && (q.r.cfg[1:0] == ACS_CLK_ASYNC); // [R17]
    assign channel_o = q.r.sc1[4:0];
    assign irq_o = q.r.sc1[ACS_SC1_FLAG] & q.r.sc1[ACS_SC1_IEN]; // [R09] [R24]
endmodule

// ===== dv/acs_partner.sv
// Analog source and hardware trigger source model
`timescale 1ns/1ps
module acs_partner (
    // Bench side
    input wire logic clk_i,
    input wire logic [9:0] level_i,
    input wire logic fire_i,
    // Sequencer side
    output logic [9:0] conv_o,
    output logic trig_o
);
    // Cycles left on the trigger pulse
    logic [2:0] left = 3'h0;
    // Result follows the level; a trigger request becomes a four-cycle pulse
    always_ff @(posedge clk_i)
    begin
        conv_o <= level_i;
        left <= fire_i ? 3'h4 : left - 3'(left != 3'h0);
    end
    // Trigger line low outside pulses
    assign trig_o = (left != 3'h0);
endmodule

// ===== dv/acs_checker.sv
// Port assertions for the conversion sequencer
`timescale 1ns/1ps
module acs_checker
    import acs_pkg::*;
(
    // Clock and controls
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic stop_i,
    // Watched outputs
    input wire logic ack_o,
    input wire logic sample_o,
    input wire logic async_clk_en_o,
    input wire logic [4:0] channel_o,
    input wire logic irq_o,
    input wire logic [23:0] port_rd_o,
    input wire logic [23:0] port_oe_allow_o,
    input wire logic [23:0] pullup_allow_o,
    input wire logic [23:0] ibuf_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request still waiting for its answer
    sequence s_req;
        cyc_i && stb_i && !ack_o && ce_i;
    endsequence
    // Answer followed by its release
    sequence s_pulse;
        ack_o ##1 !ack_o;
    endsequence
    property p_ack_answer;
        s_req |=> ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");
    property p_ack_pulse;
        ack_o && ce_i |-> s_pulse;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle");
    property p_iso;
        ibuf_en_o == port_oe_allow_o && ibuf_en_o == pullup_allow_o;
    endproperty
    a_iso: assert property (p_iso) else $error("pin gating outputs disagree");
    property p_rd_zero;
        (port_rd_o & ~ibuf_en_o) == 24'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("isolated pin reads nonzero");
    property p_reset_out;
        $fell(rst_i) |-> !irq_o && !ack_o && ibuf_en_o == 24'hffffff && channel_o == ACS_CH_OFF;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not at reset state");
    property p_irq_fall;
        $fell(irq_o) |-> ack_o;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without access");
    property p_ch_change;
        !$stable(channel_o) |-> ack_o;
    endproperty
    a_ch_change: assert property (p_ch_change) else $error("channel changed without write");
    property p_stop_abort;
        ce_i && stop_i && !async_clk_en_o |=> !sample_o;
    endproperty
    a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort sampling");
    property p_ce_freeze;
        !ce_i |=> $stable(sample_o) && $stable(irq_o) && $stable(channel_o);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");
endmodule
bind acs_seq acs_checker u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .stop_i(stop_i),
    .ack_o(ack_o), .sample_o(sample_o), .async_clk_en_o(async_clk_en_o), .channel_o(channel_o),
    .irq_o(irq_o), .port_rd_o(port_rd_o), .port_oe_allow_o(port_oe_allow_o),
    .pullup_allow_o(pullup_allow_o), .ibuf_en_o(ibuf_en_o)
);

// ===== dv/tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb import acs_pkg::*;;
    // Bench drives
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic stop_i = 1'b0, fire = 1'b0, trig, irq_o, ack_o;
    logic [4:0] adr_i = 5'h00;
    logic [31:0] dat_i = 32'h0, dat_o, rdata;
    logic [9:0] level = 10'h000, conv;
    logic [23:0] port_in_i = 24'hffffff, port_rd_o, ibuf, oe, pu;
    int bad_count = 0, check_count = 0, waited, cycles = 0;
    // 250 MHz clock
    always #2 clk_i = ~clk_i;
    acs_partner u_far (.clk_i(clk_i), .level_i(level), .fire_i(fire), .conv_o(conv), .trig_o(trig));
    acs_seq dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .hw_trigger_in_i(trig), .conv_data_i(conv), .stop_i(stop_i), .sample_o(), .async_clk_en_o(),
        .channel_o(), .irq_o(irq_o), .port_in_i(port_in_i), .port_rd_o(port_rd_o),
        .port_oe_allow_o(oe), .pullup_allow_o(pu), .ibuf_en_o(ibuf)
    );
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic Wishbone cycle, held until ack
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 20);
        // A missing answer counts as a mismatch
        if (ack_o !== 1'b1)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, ack_o, 1'b1);
        end
        rdata = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    // Read and compare
    task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask
    // Wait for completion, giving up after limit cycles
    task automatic wait_irq(input int limit);
        waited = 0;
        while (irq_o !== 1'b1 && waited < limit)
        begin
            @(posedge clk_i);
            waited++;
        end
    endtask
    // Timing and placement for one setup
    task automatic t_time(input logic [7:0] cfg, input int ticks);
        level <= 10'h2a5;
        bus(1'b1, ACS_OFF_CFG, {24'h0, cfg});
        bus(1'b1, ACS_OFF_SC1, 32'h45);
        wait_irq(ticks + 40);
        chk(32'(waited >= ticks && waited <= ticks + 9), 32'h1);
        rdc(ACS_OFF_RH, (cfg[3:2] == ACS_MODE_10) ? 32'h02 : 32'h0);
        chk(32'(irq_o), 32'h1);
        rdc(ACS_OFF_RL, (cfg[3:2] == ACS_MODE_10) ? 32'ha5 : 32'ha9);
        chk(32'(irq_o), 32'h0);
        $display("test timing done");
    endtask
    // Compare-mode conversion
    task automatic t_cmp(input logic [7:0] sc2, input logic [9:0] lv, input logic f, input logic [7:0] h, l);
        bus(1'b1, ACS_OFF_SC2, {24'h0, sc2});
        level <= lv;
        bus(1'b1, ACS_OFF_SC1, 32'h45);
        wait_irq(60);
        chk(32'(irq_o), 32'(f));
        rdc(ACS_OFF_RH, {24'h0, h});
        rdc(ACS_OFF_RL, {24'h0, l});
    endtask
    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            stop_test();
        end
    end
    // Main sequence
    initial
    begin
        logic [4:0] offs [4];
        offs = '{ACS_OFF_SC2, ACS_OFF_CFG, ACS_OFF_CVH, ACS_OFF_CVL};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(ACS_OFF_SC1, 32'(ACS_RST_SC1));
        rdc(ACS_OFF_RL, 32'h0);
        bus(1'b1, ACS_OFF_PIN, 32'h00a50f);
        chk(32'(port_rd_o), 32'hff5af0);
        chk(32'(ibuf & oe & pu), 32'hff5af0);
        rdc(ACS_OFF_PIN, 32'h00a50f);
        bus(1'b1, 5'h02, 32'hff);
        rdc(5'h02, 32'h0);
        bus(1'b1, ACS_OFF_PIN, 32'h0);
        $display("test pins done");
        t_time(8'h08, 23);
        t_time(8'h00, 20);
        t_time(8'h18, 43);
        t_time(8'h10, 40);
        t_time(8'h0b, 1273);
        bus(1'b1, ACS_OFF_CFG, 32'h08);
        bus(1'b1, ACS_OFF_SC1, 32'h45);
        wait_irq(60);
        bus(1'b0, ACS_OFF_RH, 32'h0);
        level <= 10'h1c3;
        bus(1'b1, ACS_OFF_SC1, 32'h45);
        wait_irq(90);
        chk(32'(irq_o), 32'h0);
        rdc(ACS_OFF_RL, 32'ha5);
        wait_irq(60);
        chk(32'(irq_o), 32'h1);
        rdc(ACS_OFF_RH, 32'h01);
        rdc(ACS_OFF_RL, 32'hc3);
        $display("test blocking done");
        level <= 10'h0aa;
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, ACS_OFF_SC1, 32'h45);
            repeat (6) @(posedge clk_i);
            if (i < 4)
                bus(1'b1, offs[i], (offs[i] == ACS_OFF_CFG) ? 32'h08 : 32'h0);
            else
                stop_i <= 1'b1;
            wait_irq(60);
            stop_i <= 1'b0;
            chk(32'(irq_o), 32'h0);
        end
        rdc(ACS_OFF_RL, 32'hc3);
        bus(1'b1, ACS_OFF_SC1, 32'h45);
        ce_i <= 1'b0;
        repeat (40) @(posedge clk_i);
        chk(32'(irq_o), 32'h0);
        ce_i <= 1'b1;
        wait_irq(60);
        chk(32'(irq_o), 32'h1);
        rdc(ACS_OFF_RH, 32'h0);
        rdc(ACS_OFF_RL, 32'haa);
        $display("test abort done");
        bus(1'b1, ACS_OFF_SC2, 32'h40);
        bus(1'b1, ACS_OFF_SC1, 32'h45);
        wait_irq(50);
        chk(32'(irq_o), 32'h0);
        for (int i = 0; i < 2; i++)
        begin
            fire <= 1'b1;
            @(posedge clk_i);
            fire <= 1'b0;
            repeat (10) @(posedge clk_i);
        end
        wait_irq(60);
        chk(32'(irq_o), 32'h1);
        rdc(ACS_OFF_RL, 32'haa);
        wait_irq(60);
        chk(32'(irq_o), 32'h0);
        $display("test trigger done");
        bus(1'b1, ACS_OFF_SC2, 32'h0);
        bus(1'b1, ACS_OFF_SC1, 32'h65);
        for (int i = 0; i < 2; i++)
        begin
            wait_irq(60);
            chk(32'(irq_o), 32'h1);
            bus(1'b0, ACS_OFF_RH, 32'h0);
            bus(1'b0, ACS_OFF_RL, 32'h0);
        end
        bus(1'b1, ACS_OFF_SC1, 32'h5f);
        wait_irq(60);
        chk(32'(irq_o), 32'h0);
        $display("test continuous done");
        bus(1'b1, ACS_OFF_CVH, 32'h01);
        bus(1'b1, ACS_OFF_CVL, 32'h00);
        t_cmp(8'h30, 10'h180, 1'b1, 8'h00, 8'h80);
        t_cmp(8'h30, 10'h0ff, 1'b0, 8'h00, 8'h80);
        t_cmp(8'h30, 10'h100, 1'b1, 8'h00, 8'h00);
        t_cmp(8'h20, 10'h100, 1'b0, 8'h00, 8'h00);
        t_cmp(8'h20, 10'h0ff, 1'b1, 8'h03, 8'hff);
        $display("test compare done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(ACS_OFF_RL, 32'h0);
        $display("test reset done");
        stop_test();
    end
endmodule
